// ---- common/cmpc_defines.vh ----
// Register map, field positions, reset values and timing counts of the comparator control block
`ifndef CMPC_DEFINES_VH
`define CMPC_DEFINES_VH

// Byte offsets: instance n control word at CTRL_BASE + 4*n, status word after them
`define CMPC_CTRL_BASE 8'h00
`define CMPC_STATUS_OFS 8'h10

// Control word field positions
`define CMPC_ON_BIT 15
`define CMPC_UNUSED_BIT 14
`define CMPC_IDLE_STOP_BIT 13
`define CMPC_HYST_HI 12
`define CMPC_HYST_LO 11
`define CMPC_FILT_EN_BIT 10
`define CMPC_FCLK_BIT 9
`define CMPC_DAC_OE_BIT 8
`define CMPC_INPUT_SOURCE_SELECT_HI 7
`define CMPC_INPUT_SOURCE_SELECT_LO 6
`define CMPC_STAT_BIT 3
`define CMPC_ALT_BIT 2

// Reset value and software-writable bits (bit 14 and the status bit are not)
`define CMPC_CTRL_RST 16'h0000
`define CMPC_CTRL_WMASK 16'hbff7

// Input select codes
`define CMPC_SEL_A 2'h0
`define CMPC_SEL_B 2'h1
`define CMPC_SEL_C 2'h2
`define CMPC_SEL_D 2'h3

// Status word field positions
`define CMPC_ST_OUT_LO 0
`define CMPC_ST_ACT_LO 8
`define CMPC_ST_DAC_CONFLICT 16
`define CMPC_ST_IDLE_STOP 17

// Filter agreement samples and stretcher hold samples
`define CMPC_FILT_SAMPLES 3
`define CMPC_STRETCH_SAMPLES 4

// AXI responses
`define CMPC_RESP_OKAY 2'h0
`define CMPC_RESP_SLVERR 2'h2

`endif

// ---- logic/cmpc_filter.v ----
// Digital filter and pulse stretcher for one comparator output
`timescale 1ns/1ns
`include "cmpc_defines.vh"

module cmpc_filter #(
	parameter FILT_SAMPLES = `CMPC_FILT_SAMPLES,
	parameter STRETCH_SAMPLES = `CMPC_STRETCH_SAMPLES
) (
	input wire aclk,
	input wire aresetn,
	input wire run,
	input wire filter_en,
	input wire use_pwm_clk,
	input wire pwm_tick,
	input wire sample_in,
	output wire result
);
	localparam [31:0] STRETCH_FULL = STRETCH_SAMPLES - 1;
	localparam [7:0] STRETCH_LOAD = STRETCH_FULL[7:0];

	reg [FILT_SAMPLES-2:0] hist_r;
	reg filt_r;
	reg [7:0] stretch_r;
	reg result_r;
	wire ce;
	wire [FILT_SAMPLES-1:0] win;
	wire filt_nxt;
	wire stage;

	assign ce = use_pwm_clk ? pwm_tick : 1'b1;
	assign win = {hist_r, sample_in};
	// Output changes only when every sample in the window agrees
	assign filt_nxt = (&win) ? 1'b1 : ((~|win) ? 1'b0 : filt_r);
	assign stage = filter_en ? filt_nxt : sample_in;
	assign result = result_r;

	// A stopped comparator holds its filter cleared
	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			hist_r <= {(FILT_SAMPLES-1){1'b0}};
			filt_r <= 1'b0;
			stretch_r <= 8'h00;
			result_r <= 1'b0;
		end else if (ce) begin
			hist_r <= win[FILT_SAMPLES-2:0];
			filt_r <= filt_nxt;
			if (stage) begin
				result_r <= 1'b1;
				stretch_r <= STRETCH_LOAD;
			end else if (stretch_r != 8'h00) begin
				stretch_r <= stretch_r - 8'h01;
			end else begin
				result_r <= 1'b0;
			end
		end
	end
endmodule

// ---- logic/cmpc_top.v ----
// Comparator control registers behind an AXI4-Lite slave, with per-instance input routing
`timescale 1ns/1ns
`include "cmpc_defines.vh"

// How it works
// - On bit high runs the comparator; low holds it stopped and cleared.
// - Bit 14 is not stored and always reads back zero.
// - Idle-stop bit high stops the comparator while the device idles.
// - Any instance with idle-stop set stops every instance during idle.
// - Bits 12:11 drive the hysteresis level code: 3=20mV, 2=10mV, 1=5mV, 0=none.
// - Filter enable high filters the comparator output, low bypasses it.
// - Filter clock bit high steps filter and stretcher on PWM ticks, else system clock.
// - DAC connect bit high routes this DAC voltage to the DAC output pin.
// - Alternate bit low: code 3 selects pin D, code 2 pin C.
// - Alternate bit high: codes 3 and 2 reserved, code 1 selects gain amp output.
module cmpc_top #(
	parameter NUM_CMP = 2,
	parameter ADDR_W = 8,
	parameter FILT_SAMPLES = `CMPC_FILT_SAMPLES,
	parameter STRETCH_SAMPLES = `CMPC_STRETCH_SAMPLES
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire idle_mode,
	input wire pwm_tick,
	input wire [NUM_CMP-1:0] cmp_raw_in,
	output wire [NUM_CMP-1:0] comparator_active,
	output wire [2*NUM_CMP-1:0] hysteresis_level_select,
	output wire [NUM_CMP-1:0] input_pin_a,
	output wire [NUM_CMP-1:0] input_pin_b,
	output wire [NUM_CMP-1:0] input_pin_c,
	output wire [NUM_CMP-1:0] input_pin_d,
	output wire [NUM_CMP-1:0] second_gain_amp_output,
	output wire [NUM_CMP-1:0] dac_pin_connect,
	output wire [NUM_CMP-1:0] cmp_out
);
	localparam IW = ADDR_W - 2;
	localparam [ADDR_W-1:0] STAT_OFS = `CMPC_STATUS_OFS;
	localparam [ADDR_W-1:0] CTRL_OFS = `CMPC_CTRL_BASE;
	localparam [IW-1:0] STAT_IDX = STAT_OFS[ADDR_W-1:2];
	localparam [IW-1:0] CTRL_IDX0 = CTRL_OFS[ADDR_W-1:2];

	// Write channel state
	reg awready_r;
	reg wready_r;
	reg aw_got_r;
	reg w_got_r;
	reg [ADDR_W-1:0] aw_addr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;

	// Read channel state
	reg arready_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;

	wire wr_commit;
	wire [IW-1:0] wr_idx;
	wire [IW-1:0] rd_idx;
	wire [15:0] wr_mask;
	wire [16*NUM_CMP-1:0] ctrl_flat;
	wire [NUM_CMP-1:0] idle_stop_bits;
	wire [NUM_CMP-1:0] dac_bits;
	wire [NUM_CMP-1:0] run_bits;
	wire [NUM_CMP-1:0] filt_bits;
	wire global_idle_stop;
	wire dac_conflict;
	reg wr_hit;
	reg [31:0] rd_word;
	reg rd_hit;
	integer k;
	integer m;

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	assign wr_commit = aw_got_r & w_got_r & ~bvalid_r;
	assign wr_idx = aw_addr_r[ADDR_W-1:2];
	assign rd_idx = s_axi_araddr[ADDR_W-1:2];
	assign wr_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}} & `CMPC_CTRL_WMASK;

	assign global_idle_stop = |idle_stop_bits;
	assign dac_conflict = (dac_bits & (dac_bits - 1'b1)) != {NUM_CMP{1'b0}};

	// Write decode: control words and the read-only status word answer OKAY
	always @* begin
		wr_hit = (wr_idx == STAT_IDX);
		for (m = 0; m < NUM_CMP; m = m + 1) begin
			if (wr_idx == CTRL_IDX0 + m[IW-1:0]) begin
				wr_hit = 1'b1;
			end
		end
	end

	// Address and data are taken in either order; the response follows both
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= {ADDR_W{1'b0}};
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `CMPC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				aw_addr_r <= s_axi_awaddr;
				aw_got_r <= 1'b1;
				awready_r <= 1'b0;
			end else if (!aw_got_r && !bvalid_r && !awready_r) begin
				awready_r <= 1'b1;
			end
			if (s_axi_wvalid && wready_r) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_got_r <= 1'b1;
				wready_r <= 1'b0;
			end else if (!w_got_r && !bvalid_r && !wready_r) begin
				wready_r <= 1'b1;
			end
			if (wr_commit) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read mux: a control word reads back as stored (bit 14 zero), the status bit shows the live output
	always @* begin
		rd_word = 32'h00000000;
		rd_hit = 1'b0;
		if (rd_idx == STAT_IDX) begin
			rd_hit = 1'b1;
			for (k = 0; k < NUM_CMP; k = k + 1) begin
				rd_word[`CMPC_ST_OUT_LO + k] = filt_bits[k];
				rd_word[`CMPC_ST_ACT_LO + k] = run_bits[k];
			end
			rd_word[`CMPC_ST_DAC_CONFLICT] = dac_conflict;
			rd_word[`CMPC_ST_IDLE_STOP] = global_idle_stop;
		end
		for (k = 0; k < NUM_CMP; k = k + 1) begin
			if (rd_idx == CTRL_IDX0 + k[IW-1:0]) begin
				rd_hit = 1'b1;
				rd_word[15:0] = ctrl_flat[16*k +: 16];
				rd_word[`CMPC_STAT_BIT] = filt_bits[k];
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `CMPC_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= rd_word;
				rresp_r <= rd_hit ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end else if (!rvalid_r && !arready_r) begin
				arready_r <= 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CMP; g = g + 1) begin : inst
			localparam [31:0] IDX_FULL = CTRL_IDX0 + g;
			localparam [IW-1:0] IDX = IDX_FULL[IW-1:0];
			reg [15:0] ctrl_r;
			reg [15:0] ctrl_nxt;
			reg sync1_r;
			reg sync2_r;
			reg active_r;
			reg [1:0] hyst_r;
			reg pin_a_r;
			reg pin_b_r;
			reg pin_c_r;
			reg pin_d_r;
			reg amp_r;
			reg dac_r;
			reg run_nxt;
			reg [4:0] sel_nxt;
			wire [1:0] input_source_select;
			wire alt;

			assign input_source_select = ctrl_r[`CMPC_INPUT_SOURCE_SELECT_HI:`CMPC_INPUT_SOURCE_SELECT_LO];
			assign alt = ctrl_r[`CMPC_ALT_BIT];
			assign ctrl_flat[16*g +: 16] = ctrl_r;
			assign idle_stop_bits[g] = ctrl_r[`CMPC_IDLE_STOP_BIT];
			assign dac_bits[g] = ctrl_r[`CMPC_DAC_OE_BIT];
			assign run_bits[g] = active_r;

			always @* begin
				ctrl_nxt = (ctrl_r & ~wr_mask) | (wdata_r[15:0] & wr_mask);
				// Stopped in idle only by the shared stop, the OR of every instance's stop bit
				run_nxt = ctrl_r[`CMPC_ON_BIT] & ~(idle_mode & global_idle_stop);
				sel_nxt = 5'h00;
				if (!alt) begin
					case (input_source_select)
						`CMPC_SEL_A: sel_nxt = 5'h01;
						`CMPC_SEL_B: sel_nxt = 5'h02;
						`CMPC_SEL_C: sel_nxt = 5'h04;
						`CMPC_SEL_D: sel_nxt = 5'h08;
						default: sel_nxt = 5'h00;
					endcase
				end else if (input_source_select == `CMPC_SEL_B) begin
					sel_nxt = 5'h10;
				end
			end

			always @(posedge aclk) begin
				if (!aresetn) begin
					ctrl_r <= `CMPC_CTRL_RST;
				end else if (wr_commit && wr_idx == IDX) begin
					ctrl_r <= ctrl_nxt;
				end
			end

			// Comparator output is asynchronous to aclk
			always @(posedge aclk) begin
				if (!aresetn) begin
					sync1_r <= 1'b0;
					sync2_r <= 1'b0;
				end else begin
					sync1_r <= cmp_raw_in[g];
					sync2_r <= sync1_r;
				end
			end

			always @(posedge aclk) begin
				if (!aresetn) begin
					active_r <= 1'b0;
					hyst_r <= 2'h0;
					pin_a_r <= 1'b0;
					pin_b_r <= 1'b0;
					pin_c_r <= 1'b0;
					pin_d_r <= 1'b0;
					amp_r <= 1'b0;
					dac_r <= 1'b0;
				end else begin
					active_r <= run_nxt;
					hyst_r <= ctrl_r[`CMPC_HYST_HI:`CMPC_HYST_LO];
					pin_a_r <= sel_nxt[0];
					pin_b_r <= sel_nxt[1];
					pin_c_r <= sel_nxt[2];
					pin_d_r <= sel_nxt[3];
					amp_r <= sel_nxt[4];
					dac_r <= ctrl_r[`CMPC_DAC_OE_BIT];
				end
			end

			cmpc_filter #(
				.FILT_SAMPLES(FILT_SAMPLES),
				.STRETCH_SAMPLES(STRETCH_SAMPLES)
			) u_filt (
				.aclk(aclk),
				.aresetn(aresetn),
				.run(active_r),
				.filter_en(ctrl_r[`CMPC_FILT_EN_BIT]),
				.use_pwm_clk(ctrl_r[`CMPC_FCLK_BIT]),
				.pwm_tick(pwm_tick),
				.sample_in(sync2_r),
				.result(filt_bits[g])
			);

			assign comparator_active[g] = active_r;
			assign hysteresis_level_select[2*g +: 2] = hyst_r;
			assign input_pin_a[g] = pin_a_r;
			assign input_pin_b[g] = pin_b_r;
			assign input_pin_c[g] = pin_c_r;
			assign input_pin_d[g] = pin_d_r;
			assign second_gain_amp_output[g] = amp_r;
			assign dac_pin_connect[g] = dac_r;
			assign cmp_out[g] = filt_bits[g];
		end
	endgenerate
endmodule

// ---- bench/cmpc_monitor.sv ----
// Bus and routing checks for the comparator control block
`timescale 1ns/1ns
module cmpc_monitor #(
	parameter NUM_CMP = 2
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [NUM_CMP-1:0] comparator_active,
	input wire [NUM_CMP-1:0] input_pin_a,
	input wire [NUM_CMP-1:0] input_pin_b,
	input wire [NUM_CMP-1:0] input_pin_c,
	input wire [NUM_CMP-1:0] input_pin_d,
	input wire [NUM_CMP-1:0] second_gain_amp_output,
	input wire [NUM_CMP-1:0] cmp_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_bvalid_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_write_quiet: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_quiet: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	a_bit14_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[14])
		else $error("bit 14 read as one");
	a_select_onehot: assert property ($onehot0({input_pin_a[0], input_pin_b[0],
		input_pin_c[0], input_pin_d[0], second_gain_amp_output[0]})) else $error("two inputs");
	a_stopped_quiet: assert property (!comparator_active[0] [*4] |-> !cmp_out[0])
		else $error("stopped comparator drives output");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_out_high: cover property ($rose(cmp_out[0]));
endmodule
bind cmpc_top cmpc_monitor #(.NUM_CMP(NUM_CMP)) u_mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.comparator_active(comparator_active), .input_pin_a(input_pin_a),
	.input_pin_b(input_pin_b), .input_pin_c(input_pin_c), .input_pin_d(input_pin_d),
	.second_gain_amp_output(second_gain_amp_output), .cmp_out(cmp_out));

// ---- bench/cmpc_top_test.sv ----
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
module cmpc_top_test;
	reg aclk = 0;
	reg aresetn = 0;
	reg [7:0] aw_a = 0, ar_a = 0;
	reg aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, idle = 0, tick = 0;
	reg [31:0] w_d = 0, rv = 0;
	reg [1:0] raw = 0;
	wire aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	wire [1:0] b_rs, r_rs, act, p_a, p_b, p_c, p_d, p_g, dac, c_out;
	wire [3:0] hyst;
	wire [31:0] r_d;
	integer num_errors = 0, n_checks = 0, i;
	cmpc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v),
		.s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v),
		.s_axi_rready(r_r), .idle_mode(idle), .pwm_tick(tick), .cmp_raw_in(raw),
		.comparator_active(act), .hysteresis_level_select(hyst), .input_pin_a(p_a),
		.input_pin_b(p_b), .input_pin_c(p_c), .input_pin_d(p_d),
		.second_gain_amp_output(p_g), .dac_pin_connect(dac), .cmp_out(c_out));
	always #20 aclk = ~aclk;
	task stop_test;
		begin
			if (num_errors == 0 && n_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
			end
		end
	endtask
	task st(input integer n);
		repeat (n) @(posedge aclk);
	endtask
	task wr(input [7:0] a, input [15:0] d, input [1:0] e);
		begin
			aw_a <= a;
			w_d <= {16'h0000, d};
			aw_v <= 1'b1;
			w_v <= 1'b1;
			b_r <= 1'b1;
			do begin
				@(posedge aclk);
				if (aw_v && aw_rdy) aw_v <= 1'b0;
				if (w_v && w_rdy) w_v <= 1'b0;
			end while (!b_v);
			b_r <= 1'b0;
			chk({30'h0, b_rs}, {30'h0, e});
			// Idle edge so back-to-back calls never drive a signal twice at once
			@(posedge aclk);
		end
	endtask
	task rd(input [7:0] a, input [31:0] exp, input [1:0] e);
		begin
			ar_a <= a;
			ar_v <= 1'b1;
			r_r <= 1'b1;
			do begin
				@(posedge aclk);
				if (ar_v && ar_rdy) ar_v <= 1'b0;
			end while (!r_v);
			r_r <= 1'b0;
			chk(r_d, exp);
			chk({30'h0, r_rs}, {30'h0, e});
			@(posedge aclk);
		end
	endtask
	task t_on;
		begin
			wr(8'h00, 16'hc035, 2'h0);
			rd(8'h00, 32'h00008035, 2'h0);
			st(3);
			chk({30'h0, act}, 32'h1);
			wr(8'h00, 16'h0000, 2'h0);
			st(3);
			chk({30'h0, act}, 32'h0);
		end
	endtask
	// Slow master: response and read data must stand until taken
	task t_slow;
		begin
			aw_a <= 8'h04;
			w_d <= 32'h00001800;
			aw_v <= 1'b1;
			w_v <= 1'b1;
			do begin
				@(posedge aclk);
				if (aw_v && aw_rdy) aw_v <= 1'b0;
				if (w_v && w_rdy) w_v <= 1'b0;
			end while (!b_v);
			st(3);
			b_r <= 1'b1;
			@(posedge aclk);
			b_r <= 1'b0;
			chk({31'h0, b_v}, 32'h1);
			chk({30'h0, b_rs}, 32'h0);
			@(posedge aclk);
			ar_a <= 8'h04;
			ar_v <= 1'b1;
			do begin
				@(posedge aclk);
				if (ar_v && ar_rdy) ar_v <= 1'b0;
			end while (!r_v);
			st(3);
			r_r <= 1'b1;
			@(posedge aclk);
			r_r <= 1'b0;
			chk({31'h0, r_v}, 32'h1);
			chk(r_d, 32'h00001800);
			chk({28'h0, hyst}, 32'hc);
			@(posedge aclk);
		end
	endtask
	task t_idle;
		begin
			wr(8'h00, 16'h8000, 2'h0);
			wr(8'h04, 16'ha000, 2'h0);
			idle <= 1'b1;
			st(3);
			chk({30'h0, act}, 32'h0);
			wr(8'h04, 16'h8000, 2'h0);
			st(3);
			chk({30'h0, act}, 32'h3);
			idle <= 1'b0;
			wr(8'h00, 16'h0000, 2'h0);
			wr(8'h04, 16'h0000, 2'h0);
		end
	endtask
	task t_map;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				wr(8'h04, {3'h0, i[1:0], 11'h000}, 2'h0);
				st(2);
				chk({28'h0, hyst}, {28'h0, i[1:0], 2'h0});
			end
			for (i = 0; i < 8; i = i + 1) begin
				wr(8'h00, {8'h00, i[1:0], 3'h0, i[2], 2'h0}, 2'h0);
				st(2);
				rv = i[2] ? ((i[1:0] == 2'h1) ? 32'h10 : 32'h0) : (32'h1 << i[1:0]);
				chk({27'h0, p_g[0], p_d[0], p_c[0], p_b[0], p_a[0]}, rv);
			end
			wr(8'h04, 16'h0100, 2'h0);
			st(2);
			chk({30'h0, dac}, 32'h2);
			wr(8'h04, 16'h0000, 2'h0);
			st(2);
			chk({30'h0, dac}, 32'h0);
		end
	endtask
	task t_filt;
		begin
			wr(8'h00, 16'h8000, 2'h0);
			raw <= 2'h1;
			st(6);
			chk({30'h0, c_out}, 32'h1);
			raw <= 2'h0;
			st(8);
			wr(8'h00, 16'h8400, 2'h0);
			raw <= 2'h1;
			@(posedge aclk);
			raw <= 2'h0;
			rv = 0;
			repeat (10) begin
				@(posedge aclk);
				rv = rv | c_out;
			end
			chk(rv, 32'h0);
			wr(8'h00, 16'h8600, 2'h0);
			raw <= 2'h1;
			st(10);
			chk({30'h0, c_out}, 32'h0);
			repeat (5) begin
				tick <= 1'b1;
				@(posedge aclk);
				tick <= 1'b0;
				@(posedge aclk);
			end
			st(2);
			chk({30'h0, c_out}, 32'h1);
			raw <= 2'h0;
			wr(8'h00, 16'h0000, 2'h0);
			st(5);
			chk({30'h0, c_out}, 32'h0);
		end
	endtask
	task t_bad;
		begin
			wr(8'h08, 16'h8000, 2'h2);
			rd(8'h08, 32'h0, 2'h2);
			wr(8'h10, 16'hffff, 2'h0);
			rd(8'h10, 32'h0, 2'h0);
			rd(8'h00, 32'h0, 2'h0);
		end
	endtask
	initial begin
		st(2);
		aresetn <= 1'b1;
		st(2);
		t_on;
		t_idle;
		t_map;
		t_filt;
		t_slow;
		t_bad;
		stop_test;
	end
	initial begin
		#100000;
		num_errors = num_errors + 1;
		stop_test;
	end
endmodule
